// File: logic/pts_pkg.sv
package pts_pkg;

	// ==========================================================
	// Register map (byte addresses)
	localparam logic [4:0] ADDR_CTRL     = 5'h00;
	localparam logic [4:0] ADDR_VREQ     = 5'h04;
	localparam logic [4:0] ADDR_THRESH   = 5'h08;
	localparam logic [4:0] ADDR_LIVE     = 5'h0c;
	localparam logic [4:0] ADDR_IRQ_STAT = 5'h10;
	localparam logic [4:0] ADDR_IRQ_MASK = 5'h14;

	// ==========================================================
	// Field positions
	localparam int CTRL_TCC_EN_BIT   = 0;
	localparam int CTRL_HOT_DRV_BIT  = 1;
	localparam int CTRL_NMI_EN_BIT   = 2;
	localparam int VREQ_SEL_LSB      = 8;
	localparam int VREQ_BUSY_BIT     = 16;
	localparam int THR_TRIP_LSB      = 8;
	localparam int IRQ_TRIP_BIT      = 0;
	localparam int IRQ_HOT_INT_BIT   = 1;
	localparam int IRQ_HOT_EXT_BIT   = 2;
	localparam int IRQ_INTERNAL_ERROR_FLAG_BIT      = 3;
	localparam int IRQ_VDONE_BIT     = 4;
	localparam int IRQ_W             = 5;

	// ==========================================================
	// Reset values
	localparam logic [2:0] CTRL_RST      = 3'h1;
	localparam logic [7:0] HOT_THR_RST   = 8'h5a;
	localparam logic [7:0] TRIP_THR_RST  = 8'h6e;
	localparam logic [4:0] IRQ_MASK_RST  = 5'h00;
	localparam logic [6:0] VCODE_RST     = 7'h00;
	localparam logic [1:0] VSEL_RST      = 2'h0;
	localparam logic       REFSEL_RST    = 1'b0;

	// ==========================================================
	// Voltage target select encodings
	localparam logic [1:0] VSEL_INVALID  = 2'h0;
	localparam logic [1:0] VSEL_CORE     = 2'h1;
	localparam logic [1:0] VSEL_UNCORE   = 2'h2;
	localparam logic [1:0] VSEL_RSVD     = 2'h3;
	// One code step in microvolts
	localparam int VSTEP_UV = 12500;

	// ==========================================================
	// Power state input commands
	localparam logic [2:0] PMODE_COLD    = 3'h0;
	localparam logic [2:0] PMODE_WARM    = 3'h1;
	localparam logic [2:0] PMODE_RUN     = 3'h2;
	localparam logic [2:0] PMODE_IDLE    = 3'h3;

	// ==========================================================
	// Timing
	localparam int CLK_PERIOD_NS   = 50;
	localparam int VSETTLE_NS      = 100;
	localparam int VSETTLE_CYC_RAW = (VSETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [3:0] VSETTLE_CYC = (VSETTLE_CYC_RAW < 1) ? 4'h1 : 4'(VSETTLE_CYC_RAW);

	// ==========================================================
	// Types
	typedef enum logic [1:0] {
		PS_COLD = 2'b00,
		PS_RUN  = 2'b01,
		PS_IDLE = 2'b11,
		PS_WARM = 2'b10
	} pts_pstate_e;

	typedef enum logic [1:0] {
		VS_IDLE   = 2'b00,
		VS_BLANK  = 2'b01,
		VS_SETTLE = 2'b11
	} pts_vseq_e;

	// Power state command that puts the device in reset
	function automatic logic is_reset_cmd(input logic [2:0] mode);
		is_reset_cmd = (mode == PMODE_COLD) || (mode == PMODE_WARM);
	endfunction

endpackage

// File: logic/pts_vid_seq.sv
`timescale 1ns/1ps
module pts_vid_seq (
	// Clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	// Request
	input  wire logic       req_i,
	input  wire logic [6:0] code_i,
	input  wire logic [1:0] sel_i,
	// Pins and status
	output logic      [6:0] code_o,
	output logic      [1:0] sel_o,
	output logic            busy_o,
	output logic            done_o
);

	pts_pkg::pts_vseq_e state_ff;
	logic [3:0]         cnt_ff;
	logic [6:0]         pend_code_ff;
	logic [1:0]         pend_sel_ff;

	// Sequencer: blank select, move code, settle, then show select
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			state_ff     <= pts_pkg::VS_IDLE;
			cnt_ff       <= 4'h0;
			code_o       <= pts_pkg::VCODE_RST;
			sel_o        <= pts_pkg::VSEL_RST;
			pend_code_ff <= pts_pkg::VCODE_RST;
			pend_sel_ff  <= pts_pkg::VSEL_RST;
			done_o       <= 1'b0;
		end else begin
			done_o <= 1'b0;
			unique case (state_ff)
				pts_pkg::VS_IDLE: begin
					if (req_i) begin
						pend_code_ff <= code_i;
						pend_sel_ff  <= sel_i;
						sel_o        <= pts_pkg::VSEL_INVALID;
						state_ff     <= pts_pkg::VS_BLANK;
					end
				end
				pts_pkg::VS_BLANK: begin
					code_o   <= pend_code_ff;
					cnt_ff   <= pts_pkg::VSETTLE_CYC;
					state_ff <= pts_pkg::VS_SETTLE;
				end
				pts_pkg::VS_SETTLE: begin
					if (cnt_ff == 4'h1) begin
						sel_o    <= pend_sel_ff;
						done_o   <= 1'b1;
						state_ff <= pts_pkg::VS_IDLE;
					end else begin
						cnt_ff <= cnt_ff - 4'h1;
					end
				end
				default: begin
					state_ff <= pts_pkg::VS_IDLE;
				end
			endcase
		end
	end

	assign busy_o = (state_ff != pts_pkg::VS_IDLE);

endmodule

// File: logic/pts_pstate.sv
`timescale 1ns/1ps
module pts_pstate (
	// Clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	// Power state command
	input  wire logic [2:0] mode_i,
	// Decoded state
	output logic            in_reset_o,
	output logic            cold_o,
	output logic            deep_idle_o
);

	pts_pkg::pts_pstate_e state_ff;
	pts_pkg::pts_pstate_e nxt_state;

	// Next state from the commanded power state
	always_comb begin
		nxt_state = state_ff;
		unique case (mode_i)
			pts_pkg::PMODE_COLD: nxt_state = pts_pkg::PS_COLD;
			pts_pkg::PMODE_WARM: nxt_state = pts_pkg::PS_WARM;
			pts_pkg::PMODE_RUN:  nxt_state = pts_pkg::PS_RUN;
			pts_pkg::PMODE_IDLE: begin
				if (state_ff == pts_pkg::PS_RUN) begin
					nxt_state = pts_pkg::PS_IDLE;
				end
			end
			default: nxt_state = state_ff;
		endcase
	end

	// State register
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			state_ff <= pts_pkg::PS_COLD;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign in_reset_o  = (state_ff == pts_pkg::PS_COLD) || (state_ff == pts_pkg::PS_WARM);
	assign cold_o      = (state_ff == pts_pkg::PS_COLD);
	assign deep_idle_o = (state_ff == pts_pkg::PS_IDLE);

endmodule

// File: logic/pts_sideband.sv
// What this block does
// - Drive a seven-bit voltage request code, 12.5 mV per step.
// - Drive target select: 00 invalid, 01 core, 10 uncore, 11 reserved.
// - Drive overheat output at maximum safe temperature; shows thermal control active.
// - External overheat activates thermal control, if enabled, until released.
// - Hold internal error output until reset command or link reset message.
// - Internal error comes with a shutdown pulse, optionally raising an NMI.
// - Drive the reference clock select strap low for 100 MHz.
`timescale 1ns/1ps
module pts_sideband (
	// Clock and reset
	input  wire logic        CORE_CLK_I,
	input  wire logic        NRST_I,
	// Register port
	input  wire logic [4:0]  REG_ADDR_I,
	input  wire logic [31:0] REG_WDATA_I,
	input  wire logic        REG_WR_I,
	input  wire logic        REG_RD_I,
	output logic      [31:0] REG_RDATA_O,
	// Interrupt
	output logic             IRQ_O,
	// Voltage request to the power IC
	output logic      [6:0]  VOLTAGE_REQUEST_CODE_O,
	output logic      [1:0]  VOLTAGE_TARGET_SELECT_O,
	// Thermal sensor and thermal pins
	input  wire logic [7:0]  TEMP_CODE_I,
	output logic             THERMAL_TRIP_N_O,
	output logic             THERMAL_TRIP_N_OE_N_O,
	input  wire logic        OVERHEAT_N_I,
	output logic             OVERHEAT_N_O,
	output logic             OVERHEAT_N_OE_N_O,
	output logic             THERMAL_CONTROL_CIRCUIT_O,
	output logic             HALT_O,
	// Internal error
	input  wire logic        INTERNAL_ERROR_I,
	input  wire logic        CHIP_LINK_RESET_I,
	output logic             INTERNAL_ERROR_FLAG_O,
	output logic             SHUTDOWN_O,
	output logic             NMI_O,
	// Power state sequencing
	input  wire logic [2:0]  POWER_STATE_INPUT_I,
	output logic             CORE_RESET_O,
	output logic             DEEP_IDLE_STATE_O,
	// Straps
	output logic             REFCLK_SELECT_STRAP_O
);

	// ==========================================================
	// Declarations
	logic [2:0]         ctrl_ff;
	logic [7:0]         hot_thr_ff;
	logic [7:0]         trip_thr_ff;
	logic [4:0]         irq_mask_ff;
	logic [4:0]         irq_stat_ff;
	logic [4:0]         nxt_irq_stat;
	logic [4:0]         irq_evt;
	logic [31:0]        rdata_ff;
	logic [31:0]        nxt_rdata;
	logic               trip_ff;
	logic               hot_int_ff;
	logic               hot_int_q_ff;
	logic               hot_ext_q_ff;
	logic               internal_error_flag_ff;
	logic               shutdown_ff;
	logic               nmi_ff;
	logic               refsel_ff;
	logic               hot_drive_ff;
	logic               hot_ext;
	logic               tcc_en;
	logic               hot_drv_en;
	logic               nmi_en;
	logic               wr_vreq;
	logic               vid_busy;
	logic               vid_done;
	logic               in_reset;
	logic               cold;
	logic               deep_idle;
	logic               internal_error_flag_clr;
	logic               internal_error_flag_set;

	// Control bit aliases
	assign tcc_en     = ctrl_ff[pts_pkg::CTRL_TCC_EN_BIT];
	assign hot_drv_en = ctrl_ff[pts_pkg::CTRL_HOT_DRV_BIT];
	assign nmi_en     = ctrl_ff[pts_pkg::CTRL_NMI_EN_BIT];

	// ==========================================================
	// Power state sequencing
	pts_pstate u_pstate (
		.clk_i       (CORE_CLK_I),
		.rst_n_i     (NRST_I),
		.mode_i      (POWER_STATE_INPUT_I),
		.in_reset_o  (in_reset),
		.cold_o      (cold),
		.deep_idle_o (deep_idle)
	);

	// Reset and idle status toward the core
	assign CORE_RESET_O      = in_reset;
	assign DEEP_IDLE_STATE_O = deep_idle;

	// ==========================================================
	// Voltage request sequencing
	// A write to the request register starts a new code; it is
	// ignored while the previous one is still settling.
	assign wr_vreq = REG_WR_I && (REG_ADDR_I == pts_pkg::ADDR_VREQ);

	pts_vid_seq u_vid_seq (
		.clk_i   (CORE_CLK_I),
		.rst_n_i (NRST_I),
		.req_i   (wr_vreq),
		.code_i  (REG_WDATA_I[6:0]),
		.sel_i   (REG_WDATA_I[pts_pkg::VREQ_SEL_LSB +: 2]),
		.code_o  (VOLTAGE_REQUEST_CODE_O),
		.sel_o   (VOLTAGE_TARGET_SELECT_O),
		.busy_o  (vid_busy),
		.done_o  (vid_done)
	);

	// ==========================================================
	// Register writes
	// Control register
	always_ff @(posedge CORE_CLK_I) begin
		if (!NRST_I) begin
			ctrl_ff <= pts_pkg::CTRL_RST;
		end else if (REG_WR_I && (REG_ADDR_I == pts_pkg::ADDR_CTRL)) begin
			ctrl_ff <= REG_WDATA_I[2:0];
		end
	end

	// Thermal thresholds
	always_ff @(posedge CORE_CLK_I) begin
		if (!NRST_I) begin
			hot_thr_ff  <= pts_pkg::HOT_THR_RST;
			trip_thr_ff <= pts_pkg::TRIP_THR_RST;
		end else if (REG_WR_I && (REG_ADDR_I == pts_pkg::ADDR_THRESH)) begin
			hot_thr_ff  <= REG_WDATA_I[7:0];
			trip_thr_ff <= REG_WDATA_I[pts_pkg::THR_TRIP_LSB +: 8];
		end
	end

	// Interrupt mask
	always_ff @(posedge CORE_CLK_I) begin
		if (!NRST_I) begin
			irq_mask_ff <= pts_pkg::IRQ_MASK_RST;
		end else if (REG_WR_I && (REG_ADDR_I == pts_pkg::ADDR_IRQ_MASK)) begin
			irq_mask_ff <= REG_WDATA_I[4:0];
		end
	end

	// ==========================================================
	// Catastrophic thermal trip
	// Latched until a cold reset; a hot die must not resume on a
	// warm reset alone.
	always_ff @(posedge CORE_CLK_I) begin
		if (!NRST_I) begin
			trip_ff <= 1'b0;
		end else if (TEMP_CODE_I > trip_thr_ff) begin
			trip_ff <= 1'b1;
		end else if (cold) begin
			trip_ff <= 1'b0;
		end
	end

	// Open drain: pull low while tripped
	assign THERMAL_TRIP_N_O      = 1'b0;
	assign THERMAL_TRIP_N_OE_N_O = ~trip_ff;
	assign HALT_O                = trip_ff;

	// ==========================================================
	// Overheat and thermal control
	// Internal hot at or above the maximum safe temperature
	always_ff @(posedge CORE_CLK_I) begin
		if (!NRST_I) begin
			hot_int_ff <= 1'b0;
		end else begin
			hot_int_ff <= (TEMP_CODE_I >= hot_thr_ff);
		end
	end

	// Pin drive register: drive low while internally hot
	always_ff @(posedge CORE_CLK_I) begin
		if (!NRST_I) begin
			hot_drive_ff <= 1'b0;
		end else begin
			hot_drive_ff <= hot_drv_en && (TEMP_CODE_I >= hot_thr_ff);
		end
	end

	// Open drain overheat pin
	assign OVERHEAT_N_O      = 1'b0;
	assign OVERHEAT_N_OE_N_O = ~hot_drive_ff;

	// A low line that we do not drive ourselves comes from the system
	assign hot_ext = ~OVERHEAT_N_I && ~hot_drive_ff;

	// Thermal control active while either source holds, if enabled
	assign THERMAL_CONTROL_CIRCUIT_O = tcc_en && (hot_int_ff || hot_ext);

	// Edge detect history for the interrupt events
	always_ff @(posedge CORE_CLK_I) begin
		if (!NRST_I) begin
			hot_int_q_ff <= 1'b0;
			hot_ext_q_ff <= 1'b0;
		end else begin
			hot_int_q_ff <= hot_int_ff;
			hot_ext_q_ff <= hot_ext;
		end
	end

	// ==========================================================
	// Internal error
	assign internal_error_flag_set = INTERNAL_ERROR_I && !internal_error_flag_ff;
	assign internal_error_flag_clr = pts_pkg::is_reset_cmd(POWER_STATE_INPUT_I) || CHIP_LINK_RESET_I;

	// Sticky flag; a new error wins over a clear in the same cycle
	always_ff @(posedge CORE_CLK_I) begin
		if (!NRST_I) begin
			internal_error_flag_ff <= 1'b0;
		end else if (INTERNAL_ERROR_I) begin
			internal_error_flag_ff <= 1'b1;
		end else if (internal_error_flag_clr) begin
			internal_error_flag_ff <= 1'b0;
		end
	end

	// One-cycle shutdown transaction and optional NMI
	always_ff @(posedge CORE_CLK_I) begin
		if (!NRST_I) begin
			shutdown_ff <= 1'b0;
			nmi_ff      <= 1'b0;
		end else begin
			shutdown_ff <= internal_error_flag_set;
			nmi_ff      <= internal_error_flag_set && nmi_en;
		end
	end

	assign INTERNAL_ERROR_FLAG_O = internal_error_flag_ff;
	assign SHUTDOWN_O            = shutdown_ff;
	assign NMI_O                 = nmi_ff;

	// ==========================================================
	// Reference clock strap
	// Only the 100 MHz selection is defined; high is reserved.
	always_ff @(posedge CORE_CLK_I) begin
		if (!NRST_I) begin
			refsel_ff <= pts_pkg::REFSEL_RST;
		end else begin
			refsel_ff <= 1'b0;
		end
	end

	assign REFCLK_SELECT_STRAP_O = refsel_ff;

	// ==========================================================
	// Interrupts
	// Event pulses into the sticky status
	always_comb begin
		irq_evt                           = 5'h00;
		irq_evt[pts_pkg::IRQ_TRIP_BIT]    = (TEMP_CODE_I > trip_thr_ff) && !trip_ff;
		irq_evt[pts_pkg::IRQ_HOT_INT_BIT] = hot_int_ff && !hot_int_q_ff;
		irq_evt[pts_pkg::IRQ_HOT_EXT_BIT] = hot_ext && !hot_ext_q_ff;
		irq_evt[pts_pkg::IRQ_INTERNAL_ERROR_FLAG_BIT]    = internal_error_flag_set;
		irq_evt[pts_pkg::IRQ_VDONE_BIT]   = vid_done;
	end

	// Read clears, a same-cycle event stays set
	always_comb begin
		nxt_irq_stat = irq_stat_ff;
		if (REG_RD_I && (REG_ADDR_I == pts_pkg::ADDR_IRQ_STAT)) begin
			nxt_irq_stat = 5'h00;
		end
		nxt_irq_stat = nxt_irq_stat | irq_evt;
	end

	// Sticky status register
	always_ff @(posedge CORE_CLK_I) begin
		if (!NRST_I) begin
			irq_stat_ff <= 5'h00;
		end else begin
			irq_stat_ff <= nxt_irq_stat;
		end
	end

	// Level interrupt while any unmasked bit is set
	assign IRQ_O = |(irq_stat_ff & irq_mask_ff);

	// ==========================================================
	// Register reads
	// Read mux; unmapped addresses return zero
	always_comb begin
		nxt_rdata = 32'h0000_0000;
		unique case (REG_ADDR_I)
			pts_pkg::ADDR_CTRL: begin
				nxt_rdata[2:0] = ctrl_ff;
			end
			pts_pkg::ADDR_VREQ: begin
				nxt_rdata[6:0]                          = VOLTAGE_REQUEST_CODE_O;
				nxt_rdata[pts_pkg::VREQ_SEL_LSB +: 2]   = VOLTAGE_TARGET_SELECT_O;
				nxt_rdata[pts_pkg::VREQ_BUSY_BIT]       = vid_busy;
			end
			pts_pkg::ADDR_THRESH: begin
				nxt_rdata[7:0]                          = hot_thr_ff;
				nxt_rdata[pts_pkg::THR_TRIP_LSB +: 8]   = trip_thr_ff;
			end
			pts_pkg::ADDR_LIVE: begin
				nxt_rdata[0]     = trip_ff;
				nxt_rdata[1]     = hot_int_ff;
				nxt_rdata[2]     = hot_ext;
				nxt_rdata[3]     = THERMAL_CONTROL_CIRCUIT_O;
				nxt_rdata[4]     = internal_error_flag_ff;
				nxt_rdata[5]     = in_reset;
				nxt_rdata[6]     = deep_idle;
				nxt_rdata[15:8]  = TEMP_CODE_I;
				nxt_rdata[18:16] = POWER_STATE_INPUT_I;
			end
			pts_pkg::ADDR_IRQ_STAT: begin
				nxt_rdata[4:0] = irq_stat_ff;
			end
			pts_pkg::ADDR_IRQ_MASK: begin
				nxt_rdata[4:0] = irq_mask_ff;
			end
			default: begin
				nxt_rdata = 32'h0000_0000;
			end
		endcase
	end

	// Read data valid only in the cycle after the strobe
	always_ff @(posedge CORE_CLK_I) begin
		if (!NRST_I) begin
			rdata_ff <= 32'h0000_0000;
		end else if (REG_RD_I) begin
			rdata_ff <= nxt_rdata;
		end else begin
			rdata_ff <= 32'h0000_0000;
		end
	end

	assign REG_RDATA_O = rdata_ff;

endmodule

// File: tb/pts_pwr_partner.sv
`timescale 1ns/1ps
module pts_pwr_partner (
	// Clock
	input  wire logic        clk_i,
	// Voltage request from the device
	input  wire logic [6:0]  code_i,
	input  wire logic [1:0]  sel_i,
	// Open-drain thermal pins of the device
	input  wire logic        trip_o_i,
	input  wire logic        trip_oe_n_i,
	input  wire logic        hot_o_i,
	input  wire logic        hot_oe_n_i,
	// System side pulls the overheat line
	input  wire logic        sys_hot_i,
	// Wired line levels and rail settings
	output logic             trip_n_o,
	output logic             hot_n_o,
	output logic      [31:0] core_uv_o,
	output logic      [31:0] uncore_uv_o
);
	// ====================
	// Pulled-up lines, low while any party pulls them
	assign trip_n_o = trip_oe_n_i ? 1'b1 : trip_o_i;
	assign hot_n_o  = (hot_oe_n_i ? 1'b1 : hot_o_i) & !sys_hot_i;

	// Rails start at zero until a qualified code arrives
	initial begin
		core_uv_o = 32'h0;
		uncore_uv_o = 32'h0;
	end

	// Power IC takes the code only while the select names a rail
	always @(posedge clk_i) begin
		if (sel_i == 2'h1) core_uv_o <= 32'(code_i) * 32'(pts_pkg::VSTEP_UV);
		if (sel_i == 2'h2) uncore_uv_o <= 32'(code_i) * 32'(pts_pkg::VSTEP_UV);
	end
endmodule

// File: tb/pts_sideband_asserts.sv
`timescale 1ns/1ps
module pts_sideband_asserts (
	// Clock, reset and register writes
	input  wire logic        CORE_CLK_I,
	input  wire logic        NRST_I,
	input  wire logic [4:0]  REG_ADDR_I,
	input  wire logic [31:0] REG_WDATA_I,
	input  wire logic        REG_WR_I,
	// Voltage request
	input  wire logic [6:0]  VOLTAGE_REQUEST_CODE_O,
	input  wire logic [1:0]  VOLTAGE_TARGET_SELECT_O,
	// Thermal
	input  wire logic [7:0]  TEMP_CODE_I,
	input  wire logic        THERMAL_TRIP_N_OE_N_O,
	input  wire logic        OVERHEAT_N_I,
	input  wire logic        THERMAL_CONTROL_CIRCUIT_O,
	input  wire logic        HALT_O,
	// Internal error and power state
	input  wire logic        INTERNAL_ERROR_I,
	input  wire logic        CHIP_LINK_RESET_I,
	input  wire logic        INTERNAL_ERROR_FLAG_O,
	input  wire logic        SHUTDOWN_O,
	input  wire logic        NMI_O,
	input  wire logic [2:0]  POWER_STATE_INPUT_I,
	input  wire logic        CORE_RESET_O,
	input  wire logic        REFCLK_SELECT_STRAP_O
);
	// ====================
	// Shadow of the sequencer busy window and the accepted request
	logic [1:0] bcnt_ff;
	logic [6:0] wcode_ff;
	logic [1:0] wsel_ff;
	logic       acc;
	assign acc = REG_WR_I && (REG_ADDR_I == pts_pkg::ADDR_VREQ) && (bcnt_ff == 2'h0);

	// Busy lasts three cycles after an accepted write
	always_ff @(posedge CORE_CLK_I) begin
		if (!NRST_I) bcnt_ff <= 2'h0;
		else if (acc) bcnt_ff <= 2'h3;
		else if (bcnt_ff != 2'h0) bcnt_ff <= bcnt_ff - 2'h1;
	end

	// Capture of the requested code and select
	always_ff @(posedge CORE_CLK_I) begin
		if (acc) begin
			wcode_ff <= REG_WDATA_I[6:0];
			wsel_ff <= REG_WDATA_I[9:8];
		end
	end

	// ====================
	default clocking @(posedge CORE_CLK_I); endclocking
	default disable iff (!NRST_I);

	// Select blanked, then code and select shown together
	sequence s_blank;
		(VOLTAGE_TARGET_SELECT_O == 2'h0) [*3];
	endsequence
	sequence s_show;
		(VOLTAGE_TARGET_SELECT_O == wsel_ff) && (VOLTAGE_REQUEST_CODE_O == wcode_ff);
	endsequence

	a_vid_order: assert property (acc |=> s_blank ##1 s_show)
		else $error("voltage request out of order");
	a_code_blank: assert property ($changed(VOLTAGE_REQUEST_CODE_O) |-> VOLTAGE_TARGET_SELECT_O == 2'h0)
		else $error("code changed while select valid");
	a_strap_low: assert property (REFCLK_SELECT_STRAP_O == 1'b0)
		else $error("strap not low");
	a_trip_halt: assert property ((TEMP_CODE_I > pts_pkg::TRIP_THR_RST) |-> ##[1:2] (HALT_O && !THERMAL_TRIP_N_OE_N_O))
		else $error("trip not raised");
	a_trip_hold: assert property (HALT_O && !CORE_RESET_O |=> HALT_O)
		else $error("halt dropped outside reset");
	a_hot_tcc: assert property (!OVERHEAT_N_I |-> THERMAL_CONTROL_CIRCUIT_O)
		else $error("thermal control off while line low");
	a_internal_error_flag_set: assert property (INTERNAL_ERROR_I |=> INTERNAL_ERROR_FLAG_O)
		else $error("error flag not set");
	a_internal_error_flag_hold: assert property (INTERNAL_ERROR_FLAG_O && POWER_STATE_INPUT_I > 3'h1 && !CHIP_LINK_RESET_I |=> INTERNAL_ERROR_FLAG_O)
		else $error("error flag dropped early");
	a_shut_pulse: assert property (SHUTDOWN_O == $rose(INTERNAL_ERROR_FLAG_O))
		else $error("shutdown pulse misplaced");
	a_nmi_pair: assert property (NMI_O |-> SHUTDOWN_O)
		else $error("nmi without shutdown");
endmodule

bind pts_sideband pts_sideband_asserts u_chk (
	.CORE_CLK_I, .NRST_I, .REG_ADDR_I, .REG_WDATA_I, .REG_WR_I,
	.VOLTAGE_REQUEST_CODE_O, .VOLTAGE_TARGET_SELECT_O, .TEMP_CODE_I, .THERMAL_TRIP_N_OE_N_O,
	.OVERHEAT_N_I, .THERMAL_CONTROL_CIRCUIT_O, .HALT_O, .INTERNAL_ERROR_I, .CHIP_LINK_RESET_I,
	.INTERNAL_ERROR_FLAG_O, .SHUTDOWN_O, .NMI_O, .POWER_STATE_INPUT_I, .CORE_RESET_O,
	.REFCLK_SELECT_STRAP_O
);

// File: tb/pts_sideband_tb.sv
`timescale 1ns/1ps
module pts_sideband_tb;
	// ====================
	// Stimulus and observed signals
	logic        clk = 1'b0;
	logic        nrst, wr_s, rd_s, internal_error_flag, lrst, sys_hot;
	logic [4:0]  addr;
	logic [31:0] wdata, rdata, d, core_uv, unc_uv, ecore, eunc;
	logic [7:0]  temp;
	logic [2:0]  pmode;
	logic [6:0]  vcode;
	logic [1:0]  vsel;
	logic        irq, trip_o, trip_oe_n, hot_o, hot_oe_n, trip_n, hot_n, thermal_control_circuit, halt;
	logic        flag, shut, nmi, core_rst, idle, strap;
	int          err_total = 0;
	int          n_checks = 0;

	// Voltage rows: request beside the pins it should give
	typedef struct { logic [6:0] code; logic [1:0] sel; } pts_vrow_s;
	pts_vrow_s rows [5] = '{'{7'h48, 2'h1}, '{7'h20, 2'h2}, '{7'h7f, 2'h1},
		'{7'h00, 2'h2}, '{7'h11, 2'h3}};

	// Clock of 50 ns period
	always #25 clk = ~clk;

	pts_sideband uut (
		.CORE_CLK_I(clk), .NRST_I(nrst), .REG_ADDR_I(addr), .REG_WDATA_I(wdata),
		.REG_WR_I(wr_s), .REG_RD_I(rd_s), .REG_RDATA_O(rdata), .IRQ_O(irq),
		.VOLTAGE_REQUEST_CODE_O(vcode), .VOLTAGE_TARGET_SELECT_O(vsel), .TEMP_CODE_I(temp),
		.THERMAL_TRIP_N_O(trip_o), .THERMAL_TRIP_N_OE_N_O(trip_oe_n), .OVERHEAT_N_I(hot_n),
		.OVERHEAT_N_O(hot_o), .OVERHEAT_N_OE_N_O(hot_oe_n), .THERMAL_CONTROL_CIRCUIT_O(thermal_control_circuit),
		.HALT_O(halt), .INTERNAL_ERROR_I(internal_error_flag), .CHIP_LINK_RESET_I(lrst),
		.INTERNAL_ERROR_FLAG_O(flag), .SHUTDOWN_O(shut), .NMI_O(nmi),
		.POWER_STATE_INPUT_I(pmode), .CORE_RESET_O(core_rst), .DEEP_IDLE_STATE_O(idle),
		.REFCLK_SELECT_STRAP_O(strap)
	);

	pts_pwr_partner u_pwr (
		.clk_i(clk), .code_i(vcode), .sel_i(vsel), .trip_o_i(trip_o), .trip_oe_n_i(trip_oe_n),
		.hot_o_i(hot_o), .hot_oe_n_i(hot_oe_n), .sys_hot_i(sys_hot), .trip_n_o(trip_n),
		.hot_n_o(hot_n), .core_uv_o(core_uv), .uncore_uv_o(unc_uv)
	);

	// ====================
	// Bus cycles and comparisons
	task automatic wr(input logic [4:0] a, input logic [31:0] v);
		@(posedge clk);
		addr <= a;
		wdata <= v;
		wr_s <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask

	task automatic rdw(input logic [4:0] a, output logic [31:0] v);
		@(posedge clk);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		@(negedge clk);
		v = rdata;
	endtask

	task automatic wait_chk(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask

	task automatic chkb(input string n, input logic e, input logic g);
		n_checks++;
		if (g !== e) begin
			err_total++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic chkw(input string n, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			err_total++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic end_sim;
		$display("Checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	// ====================
	// Main sequence
	initial begin
		{nrst, wr_s, rd_s, internal_error_flag, lrst, sys_hot} = 6'h0;
		addr = 5'h0;
		wdata = 32'h0;
		temp = 8'h20;
		pmode = pts_pkg::PMODE_COLD;
		{ecore, eunc} = 64'h0;
		repeat (12) @(posedge clk);
		nrst <= 1'b1;
		@(negedge clk);
		chkb("core_reset", 1'b1, core_rst);
		chkb("strap", 1'b0, strap);
		chkb("trip_line", 1'b1, trip_n);
		rdw(pts_pkg::ADDR_CTRL, d);
		chkw("ctrl", {29'h0, pts_pkg::CTRL_RST}, d);
		rdw(pts_pkg::ADDR_THRESH, d);
		chkw("thresh", {16'h0, pts_pkg::TRIP_THR_RST, pts_pkg::HOT_THR_RST}, d);
		rdw(5'h1c, d);
		chkw("unmapped", 32'h0, d);
		$display("Test reset done");
		@(posedge clk);
		pmode <= pts_pkg::PMODE_RUN;
		for (int i = 0; i < 5; i++) begin
			wr(pts_pkg::ADDR_VREQ, {22'h0, rows[i].sel, 1'b0, rows[i].code});
			if (rows[i].sel == 2'h1) ecore = 32'(rows[i].code) * 32'd12500;
			if (rows[i].sel == 2'h2) eunc = 32'(rows[i].code) * 32'd12500;
			wait_chk(5);
			chkw("code", {25'h0, rows[i].code}, {25'h0, vcode});
			chkw("select", {30'h0, rows[i].sel}, {30'h0, vsel});
			chkw("core_uv", ecore, core_uv);
			chkw("uncore_uv", eunc, unc_uv);
		end
		$display("Test voltage rows done");
		wr(pts_pkg::ADDR_VREQ, 32'h130);
		wr(pts_pkg::ADDR_VREQ, 32'h255);
		wait_chk(6);
		chkw("busy_code", 32'h30, {25'h0, vcode});
		chkw("busy_select", 32'h1, {30'h0, vsel});
		rdw(pts_pkg::ADDR_IRQ_STAT, d);
		chkw("stat_vdone", 32'h10, d);
		$display("Test busy refusal done");
		wr(pts_pkg::ADDR_IRQ_MASK, 32'h1f);
		wr(pts_pkg::ADDR_CTRL, 32'h7);
		@(posedge clk);
		temp <= 8'h5a;
		wait_chk(4);
		chkb("hot_line", 1'b0, hot_n);
		chkb("tcc_int", 1'b1, thermal_control_circuit);
		chkb("irq_on", 1'b1, irq);
		rdw(pts_pkg::ADDR_IRQ_STAT, d);
		chkw("stat_hot", 32'h2, d);
		@(posedge clk);
		temp <= 8'h20;
		sys_hot <= 1'b1;
		wait_chk(4);
		chkb("tcc_ext", 1'b1, thermal_control_circuit);
		rdw(pts_pkg::ADDR_IRQ_STAT, d);
		chkw("stat_ext", 32'h4, d);
		chkb("irq_off", 1'b0, irq);
		@(posedge clk);
		sys_hot <= 1'b0;
		wait_chk(3);
		chkb("tcc_release", 1'b0, thermal_control_circuit);
		$display("Test overheat done");
		@(posedge clk);
		internal_error_flag <= 1'b1;
		@(posedge clk);
		internal_error_flag <= 1'b0;
		@(negedge clk);
		chkb("flag_set", 1'b1, flag);
		chkb("shutdown", 1'b1, shut);
		chkb("nmi", 1'b1, nmi);
		wait_chk(5);
		chkb("flag_hold", 1'b1, flag);
		@(posedge clk);
		lrst <= 1'b1;
		@(posedge clk);
		lrst <= 1'b0;
		internal_error_flag <= 1'b1;
		@(negedge clk);
		chkb("flag_link", 1'b0, flag);
		@(posedge clk);
		internal_error_flag <= 1'b0;
		temp <= 8'h6f;
		wait_chk(3);
		chkb("halt", 1'b1, halt);
		chkb("trip_low", 1'b0, trip_n);
		wr(pts_pkg::ADDR_IRQ_MASK, 32'h0);
		@(negedge clk);
		chkb("irq_masked", 1'b0, irq);
		rdw(pts_pkg::ADDR_IRQ_STAT, d);
		chkw("stat_trip", 32'hb, d);
		@(posedge clk);
		temp <= 8'h20;
		pmode <= pts_pkg::PMODE_WARM;
		wait_chk(3);
		chkb("flag_clear", 1'b0, flag);
		chkb("halt_warm", 1'b1, halt);
		@(posedge clk);
		pmode <= pts_pkg::PMODE_COLD;
		wait_chk(3);
		chkb("halt_cold", 1'b0, halt);
		@(posedge clk);
		pmode <= pts_pkg::PMODE_RUN;
		repeat (3) @(posedge clk);
		pmode <= pts_pkg::PMODE_IDLE;
		wait_chk(3);
		chkb("deep_idle", 1'b1, idle);
		chkb("core_run", 1'b0, core_rst);
		$display("Test error and power state done");
		end_sim();
	end

	// Watchdog well beyond the expected run
	initial begin
		repeat (4000) @(posedge clk);
		err_total++;
		end_sim();
	end
endmodule
